/* rtl/port_latch_and_bus_strobes.sv */
// port latches, pin drivers, external bus muxing and strobes
// assumes an AXI4-Lite master on aclk and pins outside the clock domain
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module port_latch_and_bus_strobes (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [port_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [port_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_pin,
  input wire logic external_fetch_select,
  input wire logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] port_pin_in,
  output logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] port_pin_out,
  output logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] port_pin_oe,
  input wire logic [port_pkg::PW-1:0] alt_out_p1,
  input wire logic [port_pkg::PW-1:0] alt_out_p3,
  input wire logic [port_pkg::PW-1:0] alt_out_p4,
  output logic address_latch_strobe,
  output logic program_fetch_strobe_n,
  output logic device_reset
);
  import port_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NPORT-1:0][PW-1:0] port_latch_register;
    logic [NPORT-1:0][PW-1:0] pin_out;
    logic [NPORT-1:0][PW-1:0] pin_oe;
    logic awready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ale_off;
    logic double_speed_mode;
    logic [PW-1:0] rmw_old;
    logic rmw_bit;
    logic rmw_nz;
    logic xd_pend;
    logic xd_act;
    logic xd_wr;
    logic [15:0] xd_addr;
    logic [PW-1:0] xd_data;
    logic [15:0] fetch_addr;
    logic [1:0] rst_cnt;
    logic dev_rst;
    logic ale;
    logic fetch_n;
  } port_s;
  port_s q;
  port_s d;

  strobe_if sig ();
  logic [NPORT*PW+1:0] sync_out;
  logic [NPORT-1:0][PW-1:0] pins_s;
  logic reset_pin_s;
  logic fetch_sel_s;
  logic [NPORT-1:0][PW-1:0] alt_all;
  logic ext_fetch;
  logic bus_own;
  logic aw_go;
  logic ar_go;
  logic [2:0] wport;
  logic [2:0] rport;
  logic [2:0] rmw_port;
  logic [2:0] rmw_bsel;
  logic [PW-1:0] rmw_src;
  logic [15:0] bus_addr;
  logic [31:0] rd;
  logic [1:0] rresp_v;
  logic mc_end;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // register belongs to a per-port bank at this base
  function automatic logic port_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base);
    port_hit = (a[7:5] == base[7:5]) && (a[1:0] == 2'h0)
      && (32'(a[4:2]) < NPORT);
  endfunction

  // modify a latch byte; the source is always the latch
  function automatic logic [PW-1:0] rmw_apply(input logic [PW-1:0] l,
      input logic [3:0] op, input logic [2:0] b, input logic c,
      input logic [PW-1:0] o);
    logic [PW-1:0] m;
    m = 8'h01 << b;
    case (op)
      OP_AND: rmw_apply = l & o;
      OP_OR: rmw_apply = l | o;
      OP_XOR: rmw_apply = l ^ o;
      OP_JBC: rmw_apply = l & ~m;
      OP_CPL_BIT: rmw_apply = l ^ m;
      OP_CPL: rmw_apply = ~l;
      OP_INC: rmw_apply = l + 8'h01;
      OP_DEC: rmw_apply = l - 8'h01;
      OP_DJNZ: rmw_apply = l - 8'h01;
      OP_MOV_C: rmw_apply = c ? (l | m) : (l & ~m);
      OP_CLR_BIT: rmw_apply = l & ~m;
      OP_SET_BIT: rmw_apply = l | m;
      default: rmw_apply = l;
    endcase
  endfunction

  // ****************************************************************
  // pin synchronisers and strobe timing
  // ****************************************************************
  // fetch select travels inverted so the cleared synchroniser means internal fetch
  sync2 #(.W(NPORT * PW + 2)) sync2_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({reset_pin, ~external_fetch_select, port_pin_in}),
    .dout(sync_out)
  );

  assign pins_s = sync_out[NPORT*PW-1:0];
  assign fetch_sel_s = ~sync_out[NPORT*PW];
  assign reset_pin_s = sync_out[NPORT*PW+1];
  assign ext_fetch = ~fetch_sel_s;
  assign bus_own = ext_fetch | q.xd_act;
  assign alt_all = {alt_out_p4, alt_out_p3, LATCH_RST, alt_out_p1, LATCH_RST};

  // control toward the strobe generator
  assign sig.double_speed = q.double_speed_mode;
  assign sig.ale_off = q.ale_off;
  assign sig.ext_fetch = ext_fetch;
  assign sig.xd_act = q.xd_act;
  assign sig.dev_rst = q.dev_rst;

  strobe_gen strobe_gen_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig(sig)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    rd = 32'h0000_0000;
    rresp_v = RESP_OKAY;
    wport = s_axi_awaddr[4:2];
    rport = s_axi_araddr[4:2];
    rmw_port = s_axi_wdata[RMW_PORT_LSB +: 3];
    rmw_bsel = s_axi_wdata[RMW_BIT_LSB +: 3];
    rmw_src = 8'h00;
    bus_addr = q.xd_act ? q.xd_addr : q.fetch_addr;
    aw_go = q.awready & s_axi_awvalid & s_axi_wvalid;
    ar_go = q.arready & s_axi_arvalid;
    mc_end = sig.second_half
      && (sig.slot >= (q.double_speed_mode ? HALF_DBL : HALF_STD) - 3'h1);

    // write address and data are taken together, then answered
    d.awready = ~q.awready & ~q.bvalid & s_axi_awvalid & s_axi_wvalid;
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (aw_go) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (port_hit(s_axi_awaddr, A_LATCH0)) begin
        if ((wport == 3'h0 || wport == 3'h2) && bus_own) begin
          d.bresp = RESP_SLVERR;
        end else if (s_axi_wstrb[0]) begin
          d.port_latch_register[wport] = s_axi_wdata[PW-1:0];
        end
      end else begin
        case (s_axi_awaddr)
          A_RMW: begin
            if (32'(rmw_port) >= NPORT) begin
              d.bresp = RESP_SLVERR;
            end else if ((rmw_port == 3'h0 || rmw_port == 3'h2) && bus_own) begin
              d.bresp = RESP_SLVERR;
            end else begin
              rmw_src = q.port_latch_register[rmw_port];
              d.rmw_old = rmw_src;
              d.rmw_bit = rmw_src[rmw_bsel];
              // whole byte rewritten even for one-bit operations
              d.port_latch_register[rmw_port] = rmw_apply(rmw_src,
                s_axi_wdata[RMW_OP_LSB +: 4], rmw_bsel,
                s_axi_wdata[RMW_CARRY], s_axi_wdata[RMW_OPND_LSB +: PW]);
              d.rmw_nz = |d.port_latch_register[rmw_port];
            end
          end
          A_XDATA: begin
            if (q.xd_pend || q.xd_act) begin
              d.bresp = RESP_SLVERR;
            end else begin
              d.xd_pend = 1'b1;
              d.xd_addr = s_axi_wdata[15:0];
              d.xd_data = s_axi_wdata[XD_DATA_LSB +: PW];
              d.xd_wr = s_axi_wdata[XD_WR];
            end
          end
          A_CTRL: begin
            d.ale_off = s_axi_wdata[CTRL_ALE_OFF];
            d.double_speed_mode = s_axi_wdata[CTRL_DBL];
          end
          default: d.bresp = RESP_SLVERR;
        endcase
      end
    end

    // read channel: address taken, data returned next cycle
    d.arready = ~q.arready & ~q.rvalid & s_axi_arvalid;
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (port_hit(s_axi_araddr, A_LATCH0)) begin
      rd[PW-1:0] = q.port_latch_register[rport];
    end else if (port_hit(s_axi_araddr, A_PIN0)) begin
      rd[PW-1:0] = pins_s[rport];
    end else begin
      case (s_axi_araddr)
        A_RMW_RES: rd = {22'h0, q.rmw_nz, q.rmw_bit, q.rmw_old};
        A_XDATA: rd = {7'h0, q.xd_wr, q.xd_data, q.xd_addr};
        A_CTRL: rd = {30'h0, q.double_speed_mode, q.ale_off};
        A_STAT: rd = {27'h0, bus_own, q.dev_rst, q.xd_pend | q.xd_act,
                      reset_pin_s, fetch_sel_s};
        default: rresp_v = RESP_SLVERR;
      endcase
    end
    if (ar_go) begin
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rresp_v;
    end

    // data access occupies exactly one machine cycle, switched at its last slot
    // because the strobes are decoded one slot ahead; a new request survives
    if (mc_end) begin
      d.xd_act = q.xd_pend;
      if (q.xd_pend) begin
        d.xd_pend = 1'b0;
      end
    end
    if (sig.fetch_start) begin
      d.fetch_addr = q.fetch_addr + 16'h0001;
    end

    // reset pin counted in whole machine cycles
    if (!reset_pin_s) begin
      d.rst_cnt = 2'h0;
    end else if (sig.mc_tick && q.rst_cnt != RST_MC) begin
      d.rst_cnt = q.rst_cnt + 2'h1;
    end
    d.dev_rst = reset_pin_s && (d.rst_cnt == RST_MC);
    if (q.dev_rst) begin
      d.port_latch_register = {NPORT{LATCH_RST}};
      d.xd_pend = 1'b0;
      d.xd_act = 1'b0;
      d.fetch_addr = 16'h0000;
      d.ale_off = 1'b0;
      d.double_speed_mode = 1'b0;
    end

    // pin drivers: a zero latch or a zero alternate output pulls low, otherwise the pin is released
    for (int i = 0; i < NPORT; i++) begin
      for (int b = 0; b < PW; b++) begin
        d.pin_out[i][b] = 1'b0;
        d.pin_oe[i][b] = ~(q.port_latch_register[i][b] & alt_all[i][b]);
      end
    end
    // bus cycles take ports 0 and 2 away from their latches
    if (bus_own) begin
      d.pin_out[2] = bus_addr[15:8];
      d.pin_oe[2] = 8'hFF;
      if (sig.slot == 3'h0 && !sig.second_half) begin
        d.pin_out[0] = bus_addr[7:0];
        d.pin_oe[0] = 8'hFF;
      end else if (q.xd_act && q.xd_wr && sig.second_half) begin
        d.pin_out[0] = q.xd_data;
        d.pin_oe[0] = 8'hFF;
      end else begin
        d.pin_out[0] = 8'h00;
        d.pin_oe[0] = 8'h00;
      end
    end
    d.ale = sig.ale;
    d.fetch_n = sig.fetch_n;
  end

  // ****************************************************************
  // registers and outputs
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.port_latch_register <= {NPORT{LATCH_RST}};
      q.fetch_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.awready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign port_pin_out = q.pin_out;
  assign port_pin_oe = q.pin_oe;
  assign address_latch_strobe = q.ale;
  assign program_fetch_strobe_n = q.fetch_n;
  assign device_reset = q.dev_rst;
endmodule
`default_nettype wire

/* rtl/port_pkg.sv */
// constants shared by the port latch and bus strobe block
// assumes a 40 MHz aclk that also stands in for the oscillator
package port_pkg;
  localparam int NPORT = 5;
  localparam int PW = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  // a machine cycle is two halves of 6 clocks, or of 3 in double speed
  localparam int MC_STD_CLK = 12;
  localparam int MC_DBL_CLK = 6;
  localparam logic [2:0] HALF_STD = 3'(MC_STD_CLK / 2);
  localparam logic [2:0] HALF_DBL = 3'(MC_DBL_CLK / 2);
  localparam logic [1:0] RST_MC = 2'h2;
  // register byte addresses
  localparam logic [7:0] A_LATCH0 = 8'h00;
  localparam logic [7:0] A_PIN0 = 8'h20;
  localparam logic [7:0] A_RMW = 8'h40;
  localparam logic [7:0] A_RMW_RES = 8'h44;
  localparam logic [7:0] A_XDATA = 8'h48;
  localparam logic [7:0] A_CTRL = 8'h50;
  localparam logic [7:0] A_STAT = 8'h54;
  // field positions
  localparam int CTRL_ALE_OFF = 0;
  localparam int CTRL_DBL = 1;
  localparam int RMW_PORT_LSB = 0;
  localparam int RMW_BIT_LSB = 4;
  localparam int RMW_OP_LSB = 8;
  localparam int RMW_CARRY = 12;
  localparam int RMW_OPND_LSB = 24;
  localparam int RES_BIT = 8;
  localparam int RES_NZ = 9;
  localparam int XD_DATA_LSB = 16;
  localparam int XD_WR = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    OP_AND = 4'h0, OP_OR = 4'h1, OP_XOR = 4'h2, OP_JBC = 4'h3,
    OP_CPL_BIT = 4'h4, OP_CPL = 4'h5, OP_INC = 4'h6, OP_DEC = 4'h7,
    OP_DJNZ = 4'h8, OP_MOV_C = 4'h9, OP_CLR_BIT = 4'hA, OP_SET_BIT = 4'hB
  } rmw_op_e;
endpackage

/* rtl/strobe_if.sv */
// strobe timing signals between the port block and its strobe generator
// assumes both ends run on aclk
`timescale 1ns/1ps
`default_nettype none
interface strobe_if;
  logic double_speed;
  logic ale_off;
  logic ext_fetch;
  logic xd_act;
  logic dev_rst;
  logic [2:0] slot;
  logic second_half;
  logic ale;
  logic fetch_n;
  logic mc_tick;
  logic fetch_start;
  modport gen (input double_speed, ale_off, ext_fetch, xd_act, dev_rst,
    output slot, second_half, ale, fetch_n, mc_tick, fetch_start);
  modport use_side (output double_speed, ale_off, ext_fetch, xd_act, dev_rst,
    input slot, second_half, ale, fetch_n, mc_tick, fetch_start);
endinterface
`default_nettype wire

/* rtl/sync2.sv */
// two flip-flop synchroniser for pin levels
// assumes inputs asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s q;
  sync_s d;

  // first stage feeds only the second
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule
`default_nettype wire

/* rtl/strobe_gen.sv */
// machine cycle timing, address latch and program fetch strobes
// assumes aclk is the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module strobe_gen (
  input wire logic aclk,
  input wire logic aresetn,
  strobe_if.gen sig
);
  import port_pkg::*;
  typedef struct packed {
    logic [2:0] slot;
    logic second_half;
    logic ale;
    logic fetch_n;
    logic mc_tick;
    logic fetch_start;
  } gen_s;
  gen_s q;
  gen_s d;
  logic [2:0] half;
  logic last;
  logic fetch;

  // slot counter and strobe decode from next slot
  always_comb begin
    d = q;
    half = sig.double_speed ? HALF_DBL : HALF_STD;
    last = (q.slot >= half - 3'h1);
    d.slot = last ? 3'h0 : q.slot + 3'h1;
    d.second_half = last ? ~q.second_half : q.second_half;
    d.mc_tick = last & q.second_half;
    // two pulses per machine cycle, second skipped on data access
    d.ale = (d.slot == 3'h0) & ~sig.dev_rst
      & ~(sig.ale_off & ~sig.ext_fetch)
      & ~(sig.xd_act & d.second_half);
    fetch = sig.ext_fetch & ~sig.xd_act & ~sig.dev_rst;
    d.fetch_n = ~(fetch & (d.slot != 3'h0));
    d.fetch_start = fetch & (d.slot == 3'h1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.fetch_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sig.slot = q.slot;
  assign sig.second_half = q.second_half;
  assign sig.ale = q.ale;
  assign sig.fetch_n = q.fetch_n;
  assign sig.mc_tick = q.mc_tick;
  assign sig.fetch_start = q.fetch_start;
endmodule
`default_nettype wire

/* testbench/port_strobe_monitor.sv */
// checker for the port latch and strobe block, ports only
// assumes one clock domain, aclk, with synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module port_strobe_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic reset_pin,
  input wire logic external_fetch_select,
  input wire logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] port_pin_out,
  input wire logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] port_pin_oe,
  input wire logic [port_pkg::PW-1:0] alt_out_p1,
  input wire logic address_latch_strobe,
  input wire logic program_fetch_strobe_n,
  input wire logic device_reset
);
  // ****************
  // bus and strobe properties
  // ****************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address strobe is one clock wide and at least three clocks apart
  ale_pulse_a: assert property (address_latch_strobe |=> !address_latch_strobe [*2])
    else $error("address strobe wider or closer than allowed");
  strobe_excl_a: assert property (address_latch_strobe |-> program_fetch_strobe_n)
    else $error("fetch strobe active in the address slot");
  fetch_idle_a: assert property (external_fetch_select [*6] |-> program_fetch_strobe_n)
    else $error("fetch strobe active on internal fetch");
  awready_cause_a: assert property (s_axi_awready |-> $past(s_axi_awvalid) && $past(s_axi_wvalid))
    else $error("write taken without both valids");
  resp_follow_a: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  drive_low_a: assert property ((port_pin_out[1] | port_pin_out[3] | port_pin_out[4]) == 8'h00)
    else $error("port driven high by its own driver");
  reset_len_a: assert property ($rose(device_reset) |-> $past(reset_pin, 4) && $past(reset_pin, 8))
    else $error("device reset after too short a pin pulse");
  reset_latch_a: assert property (device_reset && $past(device_reset) && $past(device_reset, 2)
    |-> port_pin_oe[1] == ~$past(alt_out_p1))
    else $error("latches not released to input during reset");
endmodule
bind port_latch_and_bus_strobes port_strobe_monitor port_strobe_monitor_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .reset_pin, .external_fetch_select,
  .port_pin_out, .port_pin_oe, .alt_out_p1, .address_latch_strobe, .program_fetch_strobe_n,
  .device_reset);
`default_nettype wire

/* testbench/pin_load_model.sv */
// pin loads and external program memory beside the port block
// assumes pull-ups on ports 1 to 4, port 0 floating when undriven
`timescale 1ns/1ps
`default_nettype none
module pin_load_model import port_pkg::*; (
  input wire logic aclk,
  input wire logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] pin_out,
  input wire logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] pin_oe,
  input wire logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] ext_low,
  input wire logic fetch_n,
  output logic [port_pkg::NPORT-1:0][port_pkg::PW-1:0] pin_level
);
  // ****************
  // wire levels
  // ****************
  logic [PW-1:0] float_q = '0;
  // a floating port 0 line shows the inverse of its last driven level
  always_ff @(posedge aclk) begin
    float_q <= (pin_oe[0] & ~pin_out[0]) | (~pin_oe[0] & float_q);
  end
  // driver wins, then memory on fetch, then external pull-down, then pull-up or the port 0 floating level
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      for (int b = 0; b < PW; b++) begin
        if (pin_oe[i][b]) pin_level[i][b] = pin_out[i][b];
        else if (i == 0 && !fetch_n) pin_level[i][b] = 1'(8'hA5 >> b);
        else if (ext_low[i][b]) pin_level[i][b] = 1'b0;
        else pin_level[i][b] = (i == 0) ? float_q[b] : 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/port_latch_and_bus_strobes_tb.sv */
// self-checking bench for the port latch and strobe block
// assumes the pin load model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module port_latch_and_bus_strobes_tb;
  import port_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, e;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic reset_pin, external_fetch_select, address_latch_strobe, program_fetch_strobe_n;
  logic device_reset, p;
  logic [NPORT-1:0][PW-1:0] port_pin_in, port_pin_out, port_pin_oe, ext_low;
  logic [PW-1:0] alt_out_p1, alt_out_p3, alt_out_p4;
  int fail_count, total_checks, cyc, na, np;
  port_latch_and_bus_strobes port_latch_and_bus_strobes_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin, .external_fetch_select,
    .port_pin_in, .port_pin_out, .port_pin_oe, .alt_out_p1, .alt_out_p3, .alt_out_p4,
    .address_latch_strobe, .program_fetch_strobe_n, .device_reset);
  pin_load_model pin_load_model_i (.aclk, .pin_out(port_pin_out), .pin_oe(port_pin_oe),
    .ext_low, .fetch_n(program_fetch_strobe_n), .pin_level(port_pin_in));
  // ****************
  // clock, timeout and tasks
  // ****************
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bus write; response accepted late so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    chk(32'(s_axi_wready), 32'h1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    chk(32'(s_axi_rresp), 32'(er));
    chk(s_axi_rdata, ed);
    s_axi_rready <= 1'b0;
  endtask
  // count address strobes and fetch strobe falls over n clocks
  task automatic cnt(input int n);
    na = 0;
    np = 0;
    repeat (n) begin
      p = program_fetch_strobe_n;
      @(posedge aclk);
      na += int'(address_latch_strobe === 1'b1);
      np += int'(p === 1'b1 && program_fetch_strobe_n === 1'b0);
    end
  endtask
  // expected port 1 byte after a modify op on 5A, bit 1, carry 0, operand 3C
  function automatic logic [7:0] rmw(input logic [3:0] op);
    case (op)
      4'h0: return 8'h5A & 8'h3C;
      4'h1: return 8'h5A | 8'h3C;
      4'h2: return 8'h5A ^ 8'h3C;
      4'h4: return 8'h58;
      4'h5: return 8'hA5;
      4'h6: return 8'h5B;
      4'h7, 4'h8: return 8'h59;
      4'h3, 4'h9, 4'hA: return 8'h58;
      default: return 8'h5A;
    endcase
  endfunction
  // ****************
  // test sequence
  // ****************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, reset_pin, ext_low} = '0;
    s_axi_wstrb = 4'hF;
    external_fetch_select = 1'b1;
    {alt_out_p1, alt_out_p3, alt_out_p4} = {3{8'hFF}};
    {fail_count, total_checks, cyc} = '0;
    wt(12);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < NPORT; i++) rd(A_LATCH0 + 8'(4 * i), 32'hFF, RESP_OKAY);
    // latch against pin, bit 1 pulled low outside
    ext_low[1] <= 8'h02;
    wr(A_LATCH0 + 8'h04, 32'h5A, RESP_OKAY);
    wt(5);
    chk(32'(port_pin_oe[1]), 32'hA5);
    rd(A_LATCH0 + 8'h04, 32'h5A, RESP_OKAY);
    rd(A_PIN0 + 8'h04, 32'h58, RESP_OKAY);
    alt_out_p3 <= 8'h0F;
    wt(5);
    chk(32'(port_pin_oe[3]), 32'hF0);
    rd(A_PIN0 + 8'h0C, 32'h0F, RESP_OKAY);
    alt_out_p3 <= 8'hFF;
    wr(A_LATCH0, 32'h0F, RESP_OKAY);
    wt(3);
    chk({port_pin_oe[0], port_pin_out[0]}, 32'hF000);
    // every modify op reads the latch, not the low pin
    for (int op = 0; op < 12; op++) begin
      wr(A_LATCH0 + 8'h04, 32'h5A, RESP_OKAY);
      wr(A_RMW, {8'h3C, 11'h0, 1'b0, 4'(op), 1'b0, 3'd1, 1'b0, 3'd1}, RESP_OKAY);
      e = rmw(4'(op));
      rd(A_LATCH0 + 8'h04, {24'h0, e}, RESP_OKAY);
      rd(A_RMW_RES, {22'h0, |e, 1'b1, 8'h5A}, RESP_OKAY);
    end
    wr(A_RMW, 32'h5, RESP_SLVERR);
    wr(A_PIN0, 32'h0, RESP_SLVERR);
    rd(8'h60, 32'h0, RESP_SLVERR);
    // internal fetch, then address strobe switched off
    cnt(120);
    chk(32'(np), 32'd0);
    chk(32'(na), 32'd20);
    wr(A_CTRL, 32'h1, RESP_OKAY);
    wt(12);
    cnt(120);
    chk(32'(na), 32'd0);
    wr(A_CTRL, 32'h0, RESP_OKAY);
    // external fetch owns ports 0 and 2
    external_fetch_select <= 1'b0;
    wt(30);
    rd(A_STAT, 32'h10, RESP_OKAY);
    chk(32'(port_pin_oe[2]), 32'hFF);
    wr(A_LATCH0 + 8'h08, 32'h0, RESP_SLVERR);
    rd(A_LATCH0 + 8'h08, 32'hFF, RESP_OKAY);
    cnt(120);
    chk(32'(na), 32'd20);
    chk(32'(np), 32'd20);
    wr(A_XDATA, 32'h01C31234, RESP_OKAY);
    cnt(120);
    chk(32'(na), 32'd19);
    chk(32'(np), 32'd18);
    rd(A_XDATA, 32'h01C31234, RESP_OKAY);
    wr(A_CTRL, 32'h2, RESP_OKAY);
    wt(24);
    cnt(120);
    chk(32'(na), 32'd40);
    chk(32'(np), 32'd40);
    wr(A_CTRL, 32'h0, RESP_OKAY);
    external_fetch_select <= 1'b1;
    wt(10);
    // reset pin: a short pulse is ignored, a long one refills the latches
    wr(A_LATCH0 + 8'h04, 32'h0, RESP_OKAY);
    reset_pin <= 1'b1;
    wt(8);
    reset_pin <= 1'b0;
    wt(6);
    rd(A_LATCH0 + 8'h04, 32'h0, RESP_OKAY);
    reset_pin <= 1'b1;
    wt(40);
    chk(32'(device_reset), 32'h1);
    reset_pin <= 1'b0;
    wt(6);
    chk(32'(device_reset), 32'h0);
    rd(A_LATCH0 + 8'h04, 32'hFF, RESP_OKAY);
    stop_test();
  end
endmodule
`default_nettype wire
